/* pkg/ovr_pkg.sv */
// constants, states and carriers for the output overvoltage fault response
// assumes one 40 MHz core clock shared by every user of this package
package ovr_pkg;

  localparam int OVR_NCH = 2;

  // action byte layout and reset value
  localparam logic [7:0] OVR_ACTION_RESET = 8'hB8;
  localparam int OVR_RESP_HI = 7;
  localparam int OVR_RESP_LO = 6;
  localparam int OVR_RETRY_HI = 5;
  localparam int OVR_RETRY_LO = 3;
  localparam int OVR_DLY_HI = 2;
  localparam int OVR_DLY_LO = 0;

  // response and retry field codes
  localparam logic [1:0] OVR_RESP_SINK = 2'h0;
  localparam logic [1:0] OVR_RESP_DELAY = 2'h1;
  localparam logic [1:0] OVR_RESP_SHUT = 2'h2;
  localparam logic [1:0] OVR_RESP_BAD = 2'h3;
  localparam logic [2:0] OVR_RETRY_NONE = 3'h0;
  localparam logic [2:0] OVR_RETRY_FOREVER = 3'h7;

  // accepted action values; the delayed forms match on bits 7:3
  localparam logic [7:0] OVR_ACT_SINK = 8'h00;
  localparam logic [7:0] OVR_ACT_LATCH = 8'h80;
  localparam logic [7:0] OVR_ACT_RETRY = 8'hB8;
  localparam logic [4:0] OVR_ACT_DLY_LATCH = 5'h08;
  localparam logic [4:0] OVR_ACT_DLY_RETRY = 5'h0F;

  // timing
  localparam int OVR_CLK_MHZ = 40;
  localparam int OVR_UNIT_NS = 10000;
  localparam int OVR_UNIT_CYCLES = (OVR_UNIT_NS * OVR_CLK_MHZ + 999) / 1000;
  localparam int OVR_STEP_MS = 1;
  localparam int OVR_MS_CYCLES = OVR_STEP_MS * OVR_CLK_MHZ * 1000;
  localparam logic [16:0] OVR_RETRY_MIN_MS = 17'h00078;
  localparam logic [16:0] OVR_RETRY_MAX_MS = 17'h147A8;

  typedef enum logic [2:0] {
    OVR_RUN,
    OVR_DEGLITCH,
    OVR_SINK,
    OVR_LATCHED,
    OVR_RETRY
  } ovr_state_t;

  typedef struct packed {
    logic operation_on;
    logic alert_mask;
    logic [16:0] restart_interval_setting;
    logic decay_done;
    logic decay_check_off;
    logic hard_fault;
  } ovr_chan_in_t;

  typedef struct packed {
    logic drive_enable;
    logic overvoltage_sink_mode;
    logic status_byte_ov;
    logic status_word_vout;
    logic status_vout_ov;
  } ovr_chan_out_t;

endpackage : ovr_pkg

/* design/ovr_fault.sv */
// output overvoltage fault response for all paged channels
// assumes pins arrive asynchronously and commands as one-cycle core pulses
`timescale 1ns/1ps

// Notes on behaviour
// R1: on overvoltage set summary, word and output status overvoltage flags
// R2: drive the alert line low on overvoltage unless masked
// R3: action 0x00 only sinks the output while overvoltage persists
// R4: action 0x80 shuts the output and never restarts by itself
// R5: action 0xB8 shuts and retries forever until off, bias loss, hard fault
// R6: action 0x4n shuts after n*10us persistence, stays off until recycled
// R7: action 0x78+n shuts after n*10us persistence, then retries
// R8: writes of unaccepted values are dropped and raise a comms fault
// R9: response field 11 is unsupported and raises a comms fault
// R10: flag clears only on clear-faults, off-then-on, or bias loss
// R11: response 01 keeps regulating for the delay, then follows retry field
// R12: response 10 shuts at once, then follows retry field
// R13: retry field 000 stays off until reset command, commanded off or bias loss
// R14: retry field 111 restarts without limit, spaced by the retry interval
// R15: bits 2:0 give the deglitch time in 10us units
// R16: host moves the action setting as one data byte
// R17: retry interval 120ms to 83.88s in 1ms steps, timed from detection
// R18: retry waits also for output decay below 12.5% unless disabled
// R19: deglitch counter restarts whenever overvoltage drops early
// R20: each page holds its own action setting and fault state
module ovr_fault
  import ovr_pkg::*;
#(
  parameter int MS_CYCLES = OVR_MS_CYCLES
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // action byte port
  input wire logic act_wr,
  input wire logic act_page,
  input wire logic [7:0] act_wdata,
  output logic [7:0] act_rdata,
  output logic cml_fault,
  // commands
  input wire logic clear_faults,
  input wire logic reset_cmd,
  // pins
  input wire logic run_pin,
  input wire logic vin_ok,
  input wire logic [OVR_NCH-1:0] ov_detect,
  // per-channel controls and results
  input wire ovr_chan_in_t chan_in [OVR_NCH],
  output ovr_chan_out_t chan_out [OVR_NCH],
  output logic alert_n
);

  localparam int SW = OVR_NCH + 2;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree

  logic [SW-1:0] sync1, sync2, sync3, filt;
  logic [SW-1:0] next_filt;
  logic run_f, vin_f;
  logic [OVR_NCH-1:0] ov_f;

  always_comb
  begin
    next_filt = (sync2 & sync3) | (filt & (sync2 | sync3));
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
    end
    else
    begin
      sync1 <= {vin_ok, run_pin, ov_detect};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end

  assign ov_f = filt[OVR_NCH-1:0];
  assign run_f = filt[OVR_NCH];
  assign vin_f = filt[OVR_NCH+1];

  ////////////////////////////////////////////////////////////////////////////
  // shared millisecond prescaler for the retry timers

  logic [15:0] pre, next_pre;
  logic ms_tick;

  always_comb
  begin
    ms_tick = (pre == 16'(MS_CYCLES - 1));
    next_pre = ms_tick ? 16'h0000 : pre + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      pre <= 16'h0000;
    else
      pre <= next_pre;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel action, state machine, timers and flags

  logic [7:0] act [OVR_NCH];
  logic [7:0] next_act [OVR_NCH];
  ovr_state_t st [OVR_NCH];
  ovr_state_t next_st [OVR_NCH];
  logic [8:0] cyc [OVR_NCH];
  logic [8:0] next_cyc [OVR_NCH];
  logic [2:0] units [OVR_NCH];
  logic [2:0] next_units [OVR_NCH];
  logic [16:0] ms [OVR_NCH];
  logic [16:0] next_ms [OVR_NCH];
  logic [OVR_NCH-1:0] flag, next_flag, en_q, en;
  ovr_chan_out_t next_out [OVR_NCH];
  logic next_alert_n, next_cml, wr_valid;
  logic [7:0] next_rdata;

  // only the five documented forms are stored; all else is refused
  always_comb
  begin
    wr_valid = (act_wdata == OVR_ACT_SINK) || (act_wdata == OVR_ACT_LATCH) ||
               (act_wdata == OVR_ACT_RETRY) ||
               (act_wdata[7:3] == OVR_ACT_DLY_LATCH) ||
               (act_wdata[7:3] == OVR_ACT_DLY_RETRY);
  end

  always_comb
  begin
    ovr_state_t off_st;
    logic [1:0] resp;
    logic [2:0] dly;
    logic [16:0] ivl;
    off_st = OVR_LATCHED;
    resp = OVR_RESP_SINK;
    dly = 3'h0;
    ivl = OVR_RETRY_MIN_MS;
    next_flag = flag;
    next_cml = cml_fault;
    if (clear_faults)
      next_cml = 1'b0;
    if (act_wr && !wr_valid)
      next_cml = 1'b1; // [R8] [R9]
    for (int c = 0; c < OVR_NCH; c++)
    begin
      en[c] = run_f && chan_in[c].operation_on;
      resp = act[c][OVR_RESP_HI:OVR_RESP_LO];
      dly = act[c][OVR_DLY_HI:OVR_DLY_LO];
      off_st = (act[c][OVR_RETRY_HI:OVR_RETRY_LO] == OVR_RETRY_FOREVER) ?
               OVR_RETRY : OVR_LATCHED; // [R5] [R7] [R13] [R14]
      // clamp the programmed interval into its legal range
      ivl = chan_in[c].restart_interval_setting;
      if (ivl < OVR_RETRY_MIN_MS)
        ivl = OVR_RETRY_MIN_MS; // [R17]
      if (ivl > OVR_RETRY_MAX_MS)
        ivl = OVR_RETRY_MAX_MS; // [R17]
      next_act[c] = act[c];
      if (act_wr && (act_page == c[0]) && wr_valid)
        next_act[c] = act_wdata; // [R8] [R16] [R20]
      next_ms[c] = ms[c];
      if (ms_tick && (ms[c] != 17'h1FFFF))
        next_ms[c] = ms[c] + 17'h00001;
      next_cyc[c] = cyc[c];
      next_units[c] = units[c];
      next_st[c] = st[c];
      case (st[c])
        OVR_RUN:
        begin
          next_cyc[c] = 9'h000;
          next_units[c] = 3'h0;
          if (en[c] && ov_f[c])
          begin
            next_ms[c] = 17'h00000; // [R17]
            case (resp)
              OVR_RESP_SINK: next_st[c] = OVR_SINK; // [R3]
              OVR_RESP_DELAY: next_st[c] = (dly == 3'h0) ? off_st :
                                           OVR_DEGLITCH; // [R6] [R11]
              default: next_st[c] = off_st; // [R4] [R12]
            endcase
          end
        end
        OVR_DEGLITCH:
        begin
          if (!ov_f[c])
          begin
            // restart the count at once so a later glitch starts from zero
            next_st[c] = OVR_RUN; // [R19]
            next_cyc[c] = 9'h000;
            next_units[c] = 3'h0;
          end
          else if (cyc[c] == 9'(OVR_UNIT_CYCLES - 1))
          begin
            next_cyc[c] = 9'h000;
            next_units[c] = units[c] + 3'h1; // [R15]
            if (units[c] + 3'h1 == dly)
              next_st[c] = off_st; // [R6] [R7] [R11]
          end
          else
            next_cyc[c] = cyc[c] + 9'h001;
        end
        OVR_SINK:
          if (!ov_f[c])
            next_st[c] = OVR_RUN; // [R3]
        OVR_LATCHED:
          if (!en[c])
            next_st[c] = OVR_RUN; // [R4] [R6] [R13]
        OVR_RETRY:
        begin
          if (!en[c])
            next_st[c] = OVR_RUN; // [R5]
          else if (chan_in[c].hard_fault)
            next_st[c] = OVR_LATCHED; // [R5] [R14]
          else if ((ms[c] >= ivl) && (chan_in[c].decay_done ||
                   chan_in[c].decay_check_off))
            next_st[c] = OVR_RUN; // [R14] [R18]
        end
        default: next_st[c] = OVR_RUN;
      endcase
      if (!vin_f || reset_cmd)
        next_st[c] = OVR_RUN; // [R6] [R7]
      if (clear_faults || (en[c] && !en_q[c]) || !vin_f)
        next_flag[c] = 1'b0; // [R10]
      if (ov_f[c])
        next_flag[c] = 1'b1; // [R1]
      next_out[c].drive_enable = en[c] && vin_f &&
        ((next_st[c] == OVR_RUN) || (next_st[c] == OVR_DEGLITCH));
      next_out[c].overvoltage_sink_mode = (next_st[c] == OVR_SINK); // [R3]
      next_out[c].status_byte_ov = next_flag[c]; // [R1]
      next_out[c].status_word_vout = next_flag[c]; // [R1]
      next_out[c].status_vout_ov = next_flag[c]; // [R1]
    end
    next_alert_n = 1'b1;
    for (int c = 0; c < OVR_NCH; c++)
      if (next_flag[c] && !chan_in[c].alert_mask)
        next_alert_n = 1'b0; // [R2]
    next_rdata = next_act[act_page]; // [R20]
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      for (int c = 0; c < OVR_NCH; c++)
      begin
        act[c] <= OVR_ACTION_RESET;
        st[c] <= OVR_RUN;
        cyc[c] <= 9'h000;
        units[c] <= 3'h0;
        ms[c] <= 17'h00000;
        chan_out[c] <= '0;
      end
      flag <= '0;
      en_q <= '0;
      alert_n <= 1'b1;
      cml_fault <= 1'b0;
      act_rdata <= OVR_ACTION_RESET;
    end
    else
    begin
      for (int c = 0; c < OVR_NCH; c++)
      begin
        act[c] <= next_act[c];
        st[c] <= next_st[c];
        cyc[c] <= next_cyc[c];
        units[c] <= next_units[c];
        ms[c] <= next_ms[c];
        chan_out[c] <= next_out[c];
      end
      flag <= next_flag;
      en_q <= en;
      alert_n <= next_alert_n;
      cml_fault <= next_cml;
      act_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_bad_write: assert property (act_wr && !wr_valid |=> cml_fault) // [R8]
    else $error("refused write did not raise comms fault");
  a_resp_bad: assert property ( // [R9]
    act_wr && act_wdata[7:6] == OVR_RESP_BAD |=> cml_fault &&
    $stable(act[0]) && $stable(act[1]))
    else $error("response 11 write not refused");

  for (genvar g = 0; g < OVR_NCH; g++)
  begin : g_chk
    sequence s_reenable;
      !en[g] ##1 (en[g] && !ov_f[g] && !clear_faults);
    endsequence
    a_flag_set: assert property (ov_f[g] |=> flag[g]) // [R1]
      else $error("overvoltage flag not set");
    a_alert_low: assert property ( // [R2]
      next_flag[g] && !chan_in[g].alert_mask |=> !alert_n)
      else $error("alert not asserted");
    a_sink_only: assert property ( // [R3]
      st[g] == OVR_SINK |-> chan_out[g].overvoltage_sink_mode &&
      !chan_out[g].drive_enable)
      else $error("sink mode output wrong");
    a_latch_hold: assert property ( // [R13]
      st[g] == OVR_LATCHED && en[g] && vin_f && !reset_cmd |=>
      st[g] == OVR_LATCHED)
      else $error("latched channel restarted");
    a_shut_now: assert property ( // [R12]
      st[g] == OVR_RUN && en[g] && ov_f[g] && vin_f && !reset_cmd &&
      act[g][7:6] == OVR_RESP_SHUT |=> !chan_out[g].drive_enable)
      else $error("response 10 did not shut at once");
    a_degl_bound: assert property ( // [R15]
      st[g] == OVR_DEGLITCH |-> units[g] < act[g][2:0])
      else $error("deglitch overran its delay");
    a_degl_drop: assert property ( // [R19]
      st[g] == OVR_DEGLITCH && !ov_f[g] |=> st[g] == OVR_RUN &&
      units[g] == 3'h0 ##1 cyc[g] == 9'h000)
      else $error("deglitch not restarted");
    a_flag_clear: assert property (s_reenable |=> !flag[g]) // [R10]
      else $error("flag not cleared on off-then-on");
    a_retry_wait: assert property ( // [R17]
      st[g] == OVR_RETRY && $past(st[g]) == OVR_RETRY && vin_f &&
      !reset_cmd && en[g] && ms[g] < OVR_RETRY_MIN_MS |=> st[g] != OVR_RUN)
      else $error("retry earlier than minimum interval");
  end

endmodule : ovr_fault

/* tb/ovr_host.sv */
// host side model of the action byte port and the command pulses
// assumes the design takes requests on the rising edge of core_clk
`timescale 1ns/1ps
module ovr_host
  import ovr_pkg::*;
(
  // clock
  input wire logic core_clk,
  // action byte port
  output logic act_wr,
  output logic act_page,
  output logic [7:0] act_wdata,
  input wire logic [7:0] act_rdata,
  // commands
  output logic clear_faults,
  output logic reset_cmd
);
  initial
  begin
    act_wr = 1'b0;
    act_page = 1'b0;
    act_wdata = 8'h5A;
    clear_faults = 1'b0;
    reset_cmd = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : step

  // one whole byte per write; data is scrambled once the strobe drops
  // an idle edge follows so a second write always re-raises the strobe
  task automatic write_act(input logic page, input logic [7:0] data);
    act_page = page;
    act_wdata = data;
    act_wr = 1'b1;
    step(1);
    act_wr = 1'b0;
    act_wdata = ~data;
    step(1);
  endtask : write_act

  task automatic read_act(input logic page, output logic [7:0] data);
    act_page = page;
    step(2);
    data = act_rdata;
  endtask : read_act

  task automatic pulse_clear();
    clear_faults = 1'b1;
    step(1);
    clear_faults = 1'b0;
  endtask : pulse_clear

  task automatic pulse_reset();
    reset_cmd = 1'b1;
    step(1);
    reset_cmd = 1'b0;
  endtask : pulse_reset
endmodule : ovr_host

/* tb/tb.sv */
// self-checking bench for the overvoltage fault response, channel 0 mainly
// assumes ovr_host drives the action port; a short ms prescaler is used
`timescale 1ns/1ps
module tb;
  import ovr_pkg::*;
  localparam int MSC = 10;
  logic core_clk, resetn, run_pin, vin_ok, reset_cmd;
  logic act_wr, act_page, cml_fault, clear_faults, alert_n, ok;
  logic [7:0] act_wdata, act_rdata, rd, prev;
  logic [OVR_NCH-1:0] ov_detect;
  ovr_chan_in_t chan_in [OVR_NCH];
  ovr_chan_out_t chan_out [OVR_NCH];
  int miscompares, cmp_count;
  string nm [9] = '{"drive", "sink", "byte_ov", "word_vout", "vout_ov",
    "alert_n", "cml", "ch1_ov", "ch1_sink"};

  ovr_fault #(.MS_CYCLES(MSC)) DUT (.core_clk(core_clk), .resetn(resetn),
    .act_wr(act_wr), .act_page(act_page), .act_wdata(act_wdata),
    .act_rdata(act_rdata), .cml_fault(cml_fault),
    .clear_faults(clear_faults), .reset_cmd(reset_cmd), .run_pin(run_pin),
    .vin_ok(vin_ok), .ov_detect(ov_detect), .chan_in(chan_in),
    .chan_out(chan_out), .alert_n(alert_n));
  ovr_host host (.core_clk(core_clk), .act_wr(act_wr), .act_page(act_page),
    .act_wdata(act_wdata), .act_rdata(act_rdata),
    .clear_faults(clear_faults), .reset_cmd(reset_cmd));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  function automatic logic get(input int s);
    case (s)
      0: return chan_out[0].drive_enable;
      1: return chan_out[0].overvoltage_sink_mode;
      2: return chan_out[0].status_byte_ov;
      3: return chan_out[0].status_word_vout;
      4: return chan_out[0].status_vout_ov;
      5: return alert_n;
      6: return cml_fault;
      7: return chan_out[1].status_vout_ov;
      default: return chan_out[1].overvoltage_sink_mode;
    endcase
  endfunction : get

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check_bit(input int s, input logic exp);
    cmp_count++;
    if (get(s) !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm[s], exp, get(s));
    end
  endtask : check_bit

  task automatic check_byte(input string n, input logic [7:0] e,
    input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : check_byte

  task automatic check_flags(input logic e);
    for (int s = 2; s < 5; s++)
      check_bit(s, e);
  endtask : check_flags

  // a wait that runs out ends the run as a mismatch
  task automatic wait_sel(input int s, input logic v, input int n);
    int i;
    for (i = 0; i < n && get(s) !== v; i++)
      host.step(1);
    if (get(s) !== v)
    begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm[s], v, get(s));
      report_and_stop();
    end
    cmp_count++;
  endtask : wait_sel

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    miscompares = 0;
    cmp_count = 0;
    resetn = 1'b0;
    run_pin = 1'b1;
    vin_ok = 1'b1;
    ov_detect = '0;
    for (int c = 0; c < OVR_NCH; c++)
      chan_in[c] = '{1'b1, 1'b0, 17'h00078, 1'b1, 1'b0, 1'b0};
    host.step(5);
    resetn = 1'b1;
    host.step(10);
    host.read_act(1'b1, rd);
    check_byte("act1", OVR_ACTION_RESET, rd);
    prev = OVR_ACTION_RESET;
    for (int i = 0; i < 256; i++)
    begin
      ok = i == 0 || i == 8'h80 || i == 8'hB8 || i[7:3] == 5'h08
        || i[7:3] == 5'h0F;
      host.write_act(1'b0, i[7:0]);
      host.read_act(1'b0, rd);
      check_byte("act0", ok ? i[7:0] : prev, rd);
      check_bit(6, !ok);
      if (ok)
        prev = i[7:0];
      else
        host.pulse_clear();
    end
    $display("test action byte done");
    host.write_act(1'b0, 8'h80);
    host.write_act(1'b1, 8'h00);
    host.read_act(1'b0, rd);
    check_byte("act0", 8'h80, rd);
    ov_detect[0] = 1'b1;
    wait_sel(2, 1'b1, 10);
    check_flags(1'b1);
    check_bit(5, 1'b0);
    check_bit(7, 1'b0);
    wait_sel(0, 1'b0, 5);
    ov_detect[0] = 1'b0;
    host.step(50);
    check_bit(0, 1'b0);
    check_flags(1'b1);
    chan_in[0].operation_on = 1'b0;
    host.step(3);
    chan_in[0].operation_on = 1'b1;
    wait_sel(0, 1'b1, 20);
    check_flags(1'b0);
    $display("test latch done");
    chan_in[1].alert_mask = 1'b1;
    ov_detect[1] = 1'b1;
    wait_sel(8, 1'b1, 10);
    check_bit(7, 1'b1);
    check_bit(0, 1'b1);
    host.step(2);
    check_bit(5, 1'b1);
    ov_detect[1] = 1'b0;
    chan_in[1].operation_on = 1'b0;
    host.step(6);
    check_bit(7, 1'b1);
    chan_in[1].operation_on = 1'b1;
    host.step(2);
    check_bit(7, 1'b0);
    chan_in[1].alert_mask = 1'b0;
    $display("test channel one done");
    host.write_act(1'b0, 8'h00);
    chan_in[0].alert_mask = 1'b1;
    ov_detect[0] = 1'b1;
    wait_sel(1, 1'b1, 10);
    check_bit(0, 1'b0);
    host.step(2);
    check_bit(5, 1'b1);
    ov_detect[0] = 1'b0;
    wait_sel(0, 1'b1, 10);
    check_bit(1, 1'b0);
    check_flags(1'b1);
    host.pulse_clear();
    host.step(1);
    check_flags(1'b0);
    chan_in[0].alert_mask = 1'b0;
    $display("test sink done");
    host.write_act(1'b0, 8'h41);
    ov_detect[0] = 1'b1;
    host.step(200);
    ov_detect[0] = 1'b0;
    host.step(300);
    check_bit(0, 1'b1);
    ov_detect[0] = 1'b1;
    host.step(300);
    check_bit(0, 1'b1);
    wait_sel(0, 1'b0, 150);
    ov_detect[0] = 1'b0;
    host.step(50);
    check_bit(0, 1'b0);
    host.pulse_reset();
    wait_sel(0, 1'b1, 20);
    ov_detect[0] = 1'b1;
    wait_sel(0, 1'b0, 420);
    ov_detect[0] = 1'b0;
    run_pin = 1'b0;
    host.step(10);
    check_bit(0, 1'b0);
    run_pin = 1'b1;
    wait_sel(0, 1'b1, 20);
    check_flags(1'b0);
    $display("test deglitch done");
    host.write_act(1'b0, 8'hB8);
    host.pulse_clear();
    for (int k = 0; k < 2; k++)
    begin
      chan_in[0].decay_done = k[0];
      ov_detect[0] = 1'b1;
      wait_sel(0, 1'b0, 10);
      ov_detect[0] = 1'b0;
      host.step(1000);
      check_bit(0, 1'b0);
      if (k == 0)
      begin
        host.step(400);
        check_bit(0, 1'b0);
        chan_in[0].decay_done = 1'b1;
      end
      wait_sel(0, 1'b1, 400);
    end
    // longer interval, decay requirement switched off
    chan_in[0].decay_done = 1'b0;
    chan_in[0].decay_check_off = 1'b1;
    chan_in[0].restart_interval_setting = 17'h00096;
    ov_detect[0] = 1'b1;
    wait_sel(0, 1'b0, 10);
    ov_detect[0] = 1'b0;
    host.step(1400);
    check_bit(0, 1'b0);
    wait_sel(0, 1'b1, 200);
    ov_detect[0] = 1'b1;
    wait_sel(0, 1'b0, 10);
    ov_detect[0] = 1'b0;
    chan_in[0].hard_fault = 1'b1;
    host.step(1500);
    check_bit(0, 1'b0);
    vin_ok = 1'b0;
    host.step(10);
    check_flags(1'b0);
    $display("test retry done");
    report_and_stop();
  end
endmodule : tb
